// file: core/flr_dev.sv
// Device end: configuration readout, self-program timing and section guard.
// Assumes the host issues one strobe per cycle and inputs are synchronous.
`timescale 1ns/1ps
module flr_dev #(
    parameter int          PROG_CYCLES = flr_pkg::PROG_CYC,
    parameter int          RWW_LIMIT   = 16'h0c00,
    parameter logic [7:0]  SIG1        = 8'h11,  // Arbitrary identity value
    parameter logic [7:0]  SIG2        = 8'h22,  // Arbitrary identity value
    parameter logic [7:0]  SIG3        = 8'h33,  // Arbitrary identity value
    parameter logic [7:0]  CAL3V       = 8'h80,
    parameter logic [7:0]  CAL5V       = 8'h80,
    parameter logic [15:0] TS25        = 16'h0140,
    parameter logic [7:0]  FUSE_LO     = 8'h62,
    parameter logic [7:0]  FUSE_HI     = 8'hdf,
    parameter logic [3:0]  FUSE_EXT    = 4'hf,
    parameter logic [5:0]  LOCK_INIT   = 6'h3f
) (
    // Clock and reset
    input  wire logic        MCLK_IN,
    input  wire logic        SRST_IN,
    // CPU-side link
    flr_if.dev               LINK,
    // Program-memory array port
    output logic [15:0]      PM_ADDR_OUT,
    input  wire logic [7:0]  PM_DATA_IN,
    output logic             PROG_BUSY_OUT
);
    // Parameter range check at elaboration; the limit is a word address of ptr[15:1]
    if (PROG_CYCLES < 1 || RWW_LIMIT < 1 || RWW_LIMIT > 32'h7fff) begin : g_bad_param
        $error("flr_dev: bad parameter");
    end

    logic        spmen;
    logic        locksel;
    logic        sigsel;
    logic [2:0]  win;
    logic        prog;
    logic [31:0] prog_cnt;
    logic        rww_busy;
    logic [5:0]  lock_bits;
    logic        pend_st;
    logic [7:0]  ld_data;
    logic        ld_valid;
    logic [7:0]  next_ld_data;
    logic        prog_start;

    // Armed store that launches a timed operation
    assign prog_start = LINK.st && pend_st && !LINK.cs_wr && !prog;

    // Arming window counter, restarted by each control write taken while the EEPROM and the programming timer are idle
    always_ff @(posedge MCLK_IN) begin
        if (SRST_IN)
            win <= 3'h0;
        else if (LINK.cs_wr && !LINK.ee_busy && !prog)
            win <= 3'h1;
        else if (win != 3'h0 && win < flr_pkg::STORE_WIN)
            win <= win + 3'h1;
        else
            win <= 3'h0;
    end

    // Select bits: set by control write, auto-cleared on use or timeout
    always_ff @(posedge MCLK_IN) begin
        if (SRST_IN) begin
            locksel <= 1'b0;
            sigsel  <= 1'b0;
            pend_st <= 1'b0;
        end else if (LINK.cs_wr && !LINK.ee_busy && !prog) begin
            locksel <= LINK.cs_wdata[flr_pkg::CS_LOCKSEL] & LINK.cs_wdata[flr_pkg::CS_SPMEN];
            sigsel  <= LINK.cs_wdata[flr_pkg::CS_SIGSEL] & LINK.cs_wdata[flr_pkg::CS_SPMEN];
            pend_st <= LINK.cs_wdata[flr_pkg::CS_SPMEN];
        end else begin
            if ((locksel || sigsel) && LINK.ld) begin
                locksel <= 1'b0;
                sigsel  <= 1'b0;
            end else begin
                if (win >= flr_pkg::LOAD_WIN)
                    sigsel <= 1'b0;
                // Lock select also serves a lock store, so it lasts the store window
                if (LINK.st || win >= flr_pkg::STORE_WIN)
                    locksel <= 1'b0;
            end
            if (LINK.st || win >= flr_pkg::STORE_WIN)
                pend_st <= 1'b0;
        end
    end

    // Enable bit: high from arming through the whole timed operation, even across reset
    always_ff @(posedge MCLK_IN) begin
        if (SRST_IN && !prog)
            spmen <= 1'b0;
        else if (LINK.cs_wr && !LINK.ee_busy && !prog)
            spmen <= LINK.cs_wdata[flr_pkg::CS_SPMEN];
        else if (prog_start || (prog && prog_cnt != 32'h1))
            spmen <= 1'b1;
        else if (prog || LINK.st || win >= flr_pkg::STORE_WIN || ((locksel || sigsel) && LINK.ld)
                 || (sigsel && win >= flr_pkg::LOAD_WIN))
            spmen <= 1'b0;
    end

    // Programming timer; reset does not abort it
    always_ff @(posedge MCLK_IN) begin
        if (prog) begin
            if (prog_cnt == 32'h1)
                prog <= 1'b0;
            prog_cnt <= prog_cnt - 32'h1;
        end else if (SRST_IN) begin
            prog     <= 1'b0;
            prog_cnt <= 32'h0;
        end else if (prog_start) begin
            prog     <= 1'b1;
            prog_cnt <= 32'(PROG_CYCLES);
        end
    end

    // Lock bits latched by a lock write store
    always_ff @(posedge MCLK_IN) begin
        if (SRST_IN)
            lock_bits <= LOCK_INIT;
        else if (LINK.st && locksel)
            lock_bits <= lock_bits & LINK.st_data[5:0];
    end

    // Busy flag set by erase or write, cleared by re-enable command
    always_ff @(posedge MCLK_IN) begin
        if (SRST_IN && !prog)
            rww_busy <= 1'b0;
        else if (prog_start && !locksel && (LINK.cs_rdata[flr_pkg::CS_ERASE_SEL]
                 || LINK.cs_rdata[flr_pkg::CS_WRITE_SEL]))
            rww_busy <= 1'b1;
        else if (LINK.cs_wr && !LINK.ee_busy && !prog && LINK.cs_wdata[flr_pkg::CS_RWWRE]
                 && LINK.cs_wdata[flr_pkg::CS_SPMEN])
            rww_busy <= 1'b0;
    end

    // Command bits held for the store that follows
    logic [1:0] op_bits;
    always_ff @(posedge MCLK_IN) begin
        if (SRST_IN)
            op_bits <= 2'h0;
        else if (LINK.cs_wr)
            op_bits <= LINK.cs_wdata[2:1];
    end

    // Load result mux
    always_comb begin
        next_ld_data = 8'hff;
        if (locksel && win <= flr_pkg::LOAD_WIN) begin
            case (LINK.ptr)
                flr_pkg::A_LOCK:     next_ld_data = {2'b11, lock_bits};
                flr_pkg::A_FUSE_LO:  next_ld_data = FUSE_LO;
                flr_pkg::A_FUSE_HI:  next_ld_data = FUSE_HI;
                flr_pkg::A_FUSE_EXT: next_ld_data = {4'hf, FUSE_EXT};
                default:             next_ld_data = 8'hff;
            endcase
        end else if (sigsel) begin
            case (LINK.ptr)
                flr_pkg::A_SIG1:  next_ld_data = SIG1;
                flr_pkg::A_SIG2:  next_ld_data = SIG2;
                flr_pkg::A_SIG3:  next_ld_data = SIG3;
                flr_pkg::A_CAL3V: next_ld_data = CAL3V;
                flr_pkg::A_CAL5V: next_ld_data = CAL5V;
                flr_pkg::A_TS_LO: next_ld_data = TS25[7:0];
                flr_pkg::A_TS_HI: next_ld_data = TS25[15:8];
                default:          next_ld_data = 8'hff;
            endcase
        end else if ((prog || rww_busy) && LINK.ptr[15:1] < 15'(RWW_LIMIT)) begin
            next_ld_data = 8'hff;
        end else begin
            next_ld_data = PM_DATA_IN;
        end
    end

    // Registered load answer
    always_ff @(posedge MCLK_IN) begin
        if (SRST_IN) begin
            ld_data  <= 8'h00;
            ld_valid <= 1'b0;
        end else begin
            ld_valid <= LINK.ld;
            if (LINK.ld)
                ld_data <= next_ld_data;
        end
    end

    // Array address register
    always_ff @(posedge MCLK_IN) begin
        if (SRST_IN)
            PM_ADDR_OUT <= 16'h0000;
        else
            PM_ADDR_OUT <= LINK.ptr;
    end

    // Busy output register
    always_ff @(posedge MCLK_IN) begin
        if (SRST_IN && !prog)
            PROG_BUSY_OUT <= 1'b0;
        else
            PROG_BUSY_OUT <= prog;
    end

    assign LINK.ld_data  = ld_data;
    assign LINK.ld_valid = ld_valid;
    assign LINK.cs_rdata = {1'b0, rww_busy, sigsel, 1'b0, locksel, op_bits, spmen};
endmodule : flr_dev

// file: core/flr_pkg.sv
// Package for the fuse, lock and signature readout block.
// Assumes one 100 MHz clock and synchronous active-high reset at both ends.
package flr_pkg;
    // Clock and timing
    localparam int          CLK_MHZ          = 100;
    localparam real         PROG_MIN_MS      = 3.7;
    localparam real         PROG_MAX_MS      = 4.5;
    localparam int          PROG_MIN_CYC     = int'($ceil(PROG_MIN_MS * 1000.0 * CLK_MHZ));
    localparam int          PROG_MAX_CYC     = int'($floor(PROG_MAX_MS * 1000.0 * CLK_MHZ));
    localparam int          PROG_CYC         = 400000;
    localparam logic [2:0]  LOAD_WIN         = 3'h3;
    localparam logic [2:0]  STORE_WIN        = 3'h4;
    // Control/status bit positions
    localparam int          CS_SPMEN         = 0;
    localparam int          CS_ERASE_SEL     = 1;
    localparam int          CS_WRITE_SEL     = 2;
    localparam int          CS_LOCKSEL       = 3;
    localparam int          CS_RWWRE         = 4;
    localparam int          CS_SIGSEL        = 5;
    localparam int          CS_RWWBUSY       = 6;
    // Configuration pointer addresses
    localparam logic [15:0] A_FUSE_LO        = 16'h0000;
    localparam logic [15:0] A_LOCK           = 16'h0001;
    localparam logic [15:0] A_FUSE_EXT       = 16'h0002;
    localparam logic [15:0] A_FUSE_HI        = 16'h0003;
    // Signature row addresses
    localparam logic [15:0] A_SIG1           = 16'h0000;
    localparam logic [15:0] A_CAL3V          = 16'h0001;
    localparam logic [15:0] A_SIG2           = 16'h0002;
    localparam logic [15:0] A_SIG3           = 16'h0004;
    localparam logic [15:0] A_TS_LO          = 16'h0005;
    localparam logic [15:0] A_TS_HI          = 16'h0007;
    localparam logic [15:0] A_CAL5V          = 16'h0009;
    // Reset values of the host's registers
    localparam logic [31:0] RST_ZERO         = 32'h0000_0000;
    // Host register offsets (byte addresses)
    localparam logic [3:0]  R_CMD            = 4'h0;
    localparam logic [3:0]  R_PTR            = 4'h4;
    localparam logic [3:0]  R_DATA           = 4'h8;
    localparam logic [3:0]  R_STAT           = 4'hc;
    // Host command codes
    localparam logic [2:0]  C_LOCKRD         = 3'h1;
    localparam logic [2:0]  C_SIGNATURE_READ_SELECT          = 3'h2;
    localparam logic [2:0]  C_LOAD           = 3'h3;
    localparam logic [2:0]  C_ERASE          = 3'h4;
    localparam logic [2:0]  C_WRITE          = 3'h5;
    localparam logic [2:0]  C_REEN           = 3'h6;
    localparam logic [2:0]  C_LOCKWR         = 3'h7;
endpackage : flr_pkg

// file: core/flr_if.sv
// Interface joining the CPU-side sequencer and the readout device.
// Assumes both ends share MCLK_IN; no tristate pins.
`timescale 1ns/1ps
interface flr_if;
    logic        cs_wr;      // Control/status write strobe
    logic [7:0]  cs_wdata;   // Control/status write data
    logic [7:0]  cs_rdata;   // Control/status read value
    logic        ld;         // Program-memory load strobe
    logic        st;         // Program-memory store strobe
    logic [15:0] ptr;        // Address pointer
    logic [7:0]  st_data;    // Store data (lock bits)
    logic [7:0]  ld_data;    // Load result
    logic        ld_valid;   // Load result valid pulse
    logic        ee_busy;    // EEPROM write in progress
    modport dev  (input cs_wr, cs_wdata, ld, st, ptr, st_data, ee_busy,
                  output cs_rdata, ld_data, ld_valid);
    modport host (output cs_wr, cs_wdata, ld, st, ptr, st_data,
                  input cs_rdata, ld_data, ld_valid, ee_busy);
endinterface : flr_if

// file: core/flr_host.sv
// CPU-side sequencer: Wishbone command registers driving the device link.
// Assumes a classic Wishbone master and a device that answers loads next cycle.
`timescale 1ns/1ps
module flr_host (
    // Clock and reset
    input  wire logic        MCLK_IN,
    input  wire logic        SRST_IN,
    // Wishbone slave
    input  wire logic        WB_CYC_IN,
    input  wire logic        WB_STB_IN,
    input  wire logic        WB_WE_IN,
    input  wire logic [3:0]  WB_ADR_IN,
    input  wire logic [3:0]  WB_SEL_IN,
    input  wire logic [31:0] WB_DAT_IN,
    output logic [31:0]      WB_DAT_OUT,
    output logic             WB_ACK_OUT,
    // EEPROM status
    input  wire logic        EE_BUSY_IN,
    // Device link
    flr_if.host              LINK
);
    typedef enum logic [4:0] {
        H_IDLE = 5'b00001,
        H_POLL = 5'b00010,
        H_CSW  = 5'b00100,
        H_OP   = 5'b01000,
        H_WAIT = 5'b10000
    } flr_hst_t;

    flr_hst_t    st;
    logic [2:0]  cmd;
    logic [15:0] ptr;
    logic [7:0]  wdat;
    logic [7:0]  rdat;
    logic        busy;
    logic        cs_wr;
    logic        ld;
    logic        str;
    logic        wb_hit;

    assign wb_hit = WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT;

    // Wishbone ack and read data, one cycle after request
    always_ff @(posedge MCLK_IN) begin
        if (SRST_IN) begin
            WB_ACK_OUT <= 1'b0;
            WB_DAT_OUT <= flr_pkg::RST_ZERO;
        end else begin
            WB_ACK_OUT <= wb_hit;
            if (wb_hit && !WB_WE_IN) begin
                case (WB_ADR_IN)
                    flr_pkg::R_PTR:  WB_DAT_OUT <= {16'h0000, ptr};
                    flr_pkg::R_DATA: WB_DAT_OUT <= {24'h000000, rdat};
                    flr_pkg::R_STAT: WB_DAT_OUT <= {16'h0000, LINK.cs_rdata, 7'h00, busy};
                    default:         WB_DAT_OUT <= flr_pkg::RST_ZERO;
                endcase
            end
        end
    end

    // Command, pointer and store data registers
    always_ff @(posedge MCLK_IN) begin
        if (SRST_IN) begin
            cmd  <= 3'h0;
            ptr  <= 16'h0000;
            wdat <= 8'hff;
        end else if (wb_hit && WB_WE_IN && !busy) begin
            if (WB_ADR_IN == flr_pkg::R_CMD && WB_SEL_IN[0])
                cmd <= WB_DAT_IN[2:0];
            if (WB_ADR_IN == flr_pkg::R_CMD && WB_SEL_IN[1])
                wdat <= WB_DAT_IN[15:8];
            if (WB_ADR_IN == flr_pkg::R_PTR && WB_SEL_IN[0])
                ptr[7:0] <= WB_DAT_IN[7:0];
            if (WB_ADR_IN == flr_pkg::R_PTR && WB_SEL_IN[1])
                ptr[15:8] <= WB_DAT_IN[15:8];
        end
    end

    // Sequencer: poll, wait EEPROM, control write then load or store
    always_ff @(posedge MCLK_IN) begin
        if (SRST_IN) begin
            st    <= H_IDLE;
            busy  <= 1'b0;
            cs_wr <= 1'b0;
            ld    <= 1'b0;
            str   <= 1'b0;
            rdat  <= 8'h00;
        end else begin
            cs_wr <= 1'b0;
            ld    <= 1'b0;
            str   <= 1'b0;
            case (st)
                H_IDLE: if (wb_hit && WB_WE_IN && WB_ADR_IN == flr_pkg::R_CMD && WB_SEL_IN[0]
                            && WB_DAT_IN[2:0] != 3'h0 && !busy) begin
                    busy <= 1'b1;
                    st   <= H_POLL;
                end
                H_POLL: if (!LINK.cs_rdata[flr_pkg::CS_SPMEN] && !EE_BUSY_IN) begin
                    cs_wr <= 1'b1;
                    st    <= H_CSW;
                end
                H_CSW: begin
                    if (cmd == flr_pkg::C_LOCKRD || cmd == flr_pkg::C_SIGNATURE_READ_SELECT || cmd == flr_pkg::C_LOAD)
                        ld <= 1'b1;
                    else if (cmd != flr_pkg::C_REEN)
                        str <= 1'b1;
                    st <= (cmd == flr_pkg::C_REEN) ? H_IDLE : H_OP;
                    busy <= (cmd != flr_pkg::C_REEN);
                end
                H_OP: st <= H_WAIT;
                H_WAIT: begin
                    if (LINK.ld_valid)
                        rdat <= LINK.ld_data;
                    if (cmd == flr_pkg::C_LOCKRD || cmd == flr_pkg::C_SIGNATURE_READ_SELECT || cmd == flr_pkg::C_LOAD
                        || !LINK.cs_rdata[flr_pkg::CS_SPMEN]) begin
                        busy <= 1'b0;
                        st   <= H_IDLE;
                    end
                end
                default: st <= H_IDLE;
            endcase
        end
    end

    // Control value for each command
    logic [7:0] csv;
    always_comb begin
        case (cmd)
            flr_pkg::C_LOCKRD: csv = 8'h09;
            flr_pkg::C_SIGNATURE_READ_SELECT:  csv = 8'h21;
            flr_pkg::C_LOAD:   csv = 8'h00;  // Plain load, nothing armed
            flr_pkg::C_ERASE:  csv = 8'h03;
            flr_pkg::C_WRITE:  csv = 8'h05;
            flr_pkg::C_REEN:   csv = 8'h11;
            flr_pkg::C_LOCKWR: csv = 8'h09;
            default:           csv = 8'h01;
        endcase
    end

    assign LINK.cs_wr    = cs_wr;
    assign LINK.cs_wdata = csv;
    assign LINK.ld       = ld;
    assign LINK.st       = str;
    assign LINK.ptr      = ptr;
    assign LINK.st_data  = wdat;
endmodule : flr_host

// file: sim/flr_sva.sv
// Checker on the link between the sequencer and the readout device.
// Assumes one clock domain; the bench instantiates it beside the link.
`timescale 1ns/1ps
module flr_sva #(
    parameter int         RWW_LIMIT = 16'h0c00,
    parameter logic [7:0] FUSE_LO   = 8'h62,
    parameter logic [7:0] SIG1      = 8'h11
) (
    // Clock and reset
    input  wire logic        MCLK_IN,
    input  wire logic        SRST_IN,
    // Link signals
    input  wire logic        cs_wr,
    input  wire logic [7:0]  cs_wdata,
    input  wire logic [7:0]  cs_rdata,
    input  wire logic        ld,
    input  wire logic        st,
    input  wire logic [15:0] ptr,
    input  wire logic [7:0]  ld_data,
    input  wire logic        ld_valid,
    input  wire logic        ee_busy
);
    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (SRST_IN);
    // Armed selects as seen in the status value, and wr_sel from the control write data
    wire en       = cs_rdata[flr_pkg::CS_SPMEN];
    wire any_sel  = cs_rdata[flr_pkg::CS_LOCKSEL] | cs_rdata[flr_pkg::CS_SIGSEL];
    wire wr_sel   = cs_wdata[flr_pkg::CS_LOCKSEL] | cs_wdata[flr_pkg::CS_SIGSEL];
    wire lock_arm = cs_rdata[flr_pkg::CS_LOCKSEL] & en;
    wire sig_arm  = cs_rdata[flr_pkg::CS_SIGSEL] & en;

    property p_ee_idle;
        cs_wr |-> !ee_busy;
    endproperty
    a_ee_idle: assert property (p_ee_idle) else $error("control write during eeprom write");
    property p_poll;
        cs_wr |-> !en;
    endproperty
    a_poll: assert property (p_poll) else $error("control write while enable still set");
    // A read or lock select is followed by a load or a store within four cycles
    property p_window;
        cs_wr && wr_sel |-> ##[1:4] (ld || st);
    endproperty
    a_window: assert property (p_window) else $error("load missing after select");
    property p_arm;
        cs_wr && wr_sel |=> en && (cs_rdata[flr_pkg::CS_LOCKSEL] == $past(cs_wdata[flr_pkg::CS_LOCKSEL]));
    endproperty
    a_arm: assert property (p_arm) else $error("select write did not arm");
    property p_clear;
        $rose(any_sel) |-> ##[1:4] !any_sel;
    endproperty
    a_clear: assert property (p_clear) else $error("select did not auto-clear");
    property p_done;
        ld_valid |-> !any_sel;
    endproperty
    a_done: assert property (p_done) else $error("select still set after read");
    property p_answer;
        ld |=> ld_valid;
    endproperty
    a_answer: assert property (p_answer) else $error("load not answered");
    property p_fuse_lo;
        ld && lock_arm && ptr == flr_pkg::A_FUSE_LO |=> ld_data == FUSE_LO;
    endproperty
    a_fuse_lo: assert property (p_fuse_lo) else $error("wrong fuse low byte");
    property p_sig1;
        ld && sig_arm && ptr == flr_pkg::A_SIG1 |=> ld_data == SIG1;
    endproperty
    a_sig1: assert property (p_sig1) else $error("wrong first identity byte");
    property p_rww;
        ld && !any_sel && cs_rdata[flr_pkg::CS_RWWBUSY] && ptr[15:1] < RWW_LIMIT |=> ld_data == 8'hff;
    endproperty
    a_rww: assert property (p_rww) else $error("busy section was readable");
    // Main scenarios
    c_lock: cover property (ld && lock_arm);
    c_sig: cover property (ld && sig_arm);
    c_rww: cover property (ld && cs_rdata[flr_pkg::CS_RWWBUSY]);
endmodule : flr_sva

// file: sim/test_fuse_lock_signature_readout.sv
// Bench: sequencer and readout device joined by the link, driven over Wishbone.
// Assumes a 100 MHz clock and a short program timer set here.
`timescale 1ns/1ps
module test_fuse_lock_signature_readout;
    localparam int          PC = 20;
    localparam logic [7:0]  S1 = 8'h5c, S2 = 8'h3a, S3 = 8'h71;  // Arbitrary identity values
    localparam logic [7:0]  C3 = 8'h9c, C5 = 8'ha7, FL = 8'he2, FH = 8'hd9;
    localparam logic [15:0] TS = 16'h0155;
    localparam logic [3:0]  FE = 4'hd;
    localparam logic [5:0]  LK = 6'h2c;
    localparam logic [15:0] CA [4] = '{16'h0001, 16'h0000, 16'h0003, 16'h0002};
    localparam logic [7:0]  CM [4] = '{8'h3f, 8'hff, 8'hff, 8'h0f};
    localparam logic [7:0]  CE [4] = '{{2'h0, LK}, FL, FH, {4'h0, FE}};
    localparam logic [15:0] SA [8] = '{16'h0, 16'h2, 16'h4, 16'h1, 16'h5, 16'h7, 16'h9, 16'h3};
    localparam logic [7:0]  SE [8] = '{S1, S2, S3, C3, TS[7:0], TS[15:8], C5, 8'hff};
    logic        mclk = 1'b0, srst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ee = 1'b0;
    logic [3:0]  adr = 4'h0, sel = 4'h0;
    logic [31:0] wdat = 32'h0, v;
    wire  [31:0] dout;
    wire         ack, prog_busy;
    wire  [15:0] pm_addr;
    wire  [7:0]  pm_data;
    int          mismatches = 0, samples_checked = 0, cycles = 0, n;

    flr_if link ();
    assign link.ee_busy = ee;
    // Array contents follow the byte address
    assign pm_data = pm_addr[7:0] ^ 8'ha5;
    flr_dev #(.PROG_CYCLES(PC), .SIG1(S1), .SIG2(S2), .SIG3(S3), .CAL3V(C3), .CAL5V(C5), .TS25(TS),
              .FUSE_LO(FL), .FUSE_HI(FH), .FUSE_EXT(FE), .LOCK_INIT(LK)) flr_dev_i (
        .MCLK_IN(mclk), .SRST_IN(srst), .LINK(link.dev), .PM_ADDR_OUT(pm_addr), .PM_DATA_IN(pm_data),
        .PROG_BUSY_OUT(prog_busy));
    flr_host flr_host_i (
        .MCLK_IN(mclk), .SRST_IN(srst), .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr),
        .WB_SEL_IN(sel), .WB_DAT_IN(wdat), .WB_DAT_OUT(dout), .WB_ACK_OUT(ack), .EE_BUSY_IN(ee),
        .LINK(link.host));
    flr_sva #(.FUSE_LO(FL), .SIG1(S1)) flr_sva_i (
        .MCLK_IN(mclk), .SRST_IN(srst), .cs_wr(link.cs_wr), .cs_wdata(link.cs_wdata),
        .cs_rdata(link.cs_rdata), .ld(link.ld), .st(link.st), .ptr(link.ptr), .ld_data(link.ld_data),
        .ld_valid(link.ld_valid), .ee_busy(link.ee_busy));

    // Clock
    initial begin
        forever #5 mclk = ~mclk;
    end

    // Hang guard
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            mismatches++;
            complete_run();
        end
    end

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask : chk

    // One classic Wishbone cycle
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hf;
        do @(posedge mclk); while (ack !== 1'b1);
        q = dout;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb

    task automatic cmd(input logic [2:0] c, input logic [15:0] p);
        wb(1'b1, flr_pkg::R_PTR, {16'h0, p}, v);
        wb(1'b1, flr_pkg::R_CMD, {29'h0, c}, v);
    endtask : cmd

    // Poll until idle, then fetch the loaded byte
    task automatic fin(output logic [31:0] q);
        do wb(1'b0, flr_pkg::R_STAT, 32'h0, q); while (q[0] !== 1'b0);
        wb(1'b0, flr_pkg::R_DATA, 32'h0, q);
    endtask : fin

    task automatic complete_run();
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : complete_run

    // Main sequence
    initial begin
        repeat (4) @(posedge mclk);
        srst <= 1'b0;
        wb(1'b0, flr_pkg::R_STAT, 32'h0, v);
        chk("status", v, flr_pkg::RST_ZERO);
        wb(1'b0, 4'h2, 32'h0, v);
        chk("unmapped", v, 32'h0);
        for (int i = 0; i < 4; i++) begin
            cmd(flr_pkg::C_LOCKRD, CA[i]);
            fin(v);
            chk("config byte", {24'h0, v[7:0] & CM[i]}, {24'h0, CE[i]});
        end
        for (int i = 0; i < 8; i++) begin
            cmd(flr_pkg::C_SIGNATURE_READ_SELECT, SA[i]);
            fin(v);
            chk("signature byte", {24'h0, v[7:0]}, {24'h0, SE[i]});
        end
        wb(1'b0, flr_pkg::R_STAT, 32'h0, v);
        chk("selects", v & 32'h2900, 32'h0);
        cmd(flr_pkg::C_LOAD, 16'h0011);
        fin(v);
        chk("plain load", {24'h0, v[7:0]}, {24'h0, 8'h11 ^ 8'ha5});
        // Erase with a one-cycle reset part-way through
        cmd(flr_pkg::C_ERASE, 16'h0040);
        do @(posedge mclk); while (prog_busy !== 1'b1);
        n = 1;
        do begin
            @(posedge mclk);
            n++;
            srst <= (n == 6);
        end while (prog_busy === 1'b1);
        chk("program time", n - 1, PC);
        wb(1'b0, flr_pkg::R_STAT, 32'h0, v);
        chk("section busy", {31'h0, v[8 + flr_pkg::CS_RWWBUSY]}, 32'h1);
        cmd(flr_pkg::C_LOAD, 16'h0040);
        fin(v);
        chk("blocked load", {24'h0, v[7:0]}, 32'hff);
        cmd(flr_pkg::C_LOAD, 16'h1802);
        fin(v);
        chk("safe load", {24'h0, v[7:0]}, {24'h0, 8'h02 ^ 8'ha5});
        // Page write keeps the section busy until re-enabled
        cmd(flr_pkg::C_WRITE, 16'h0040);
        fin(v);
        wb(1'b0, flr_pkg::R_STAT, 32'h0, v);
        chk("write busy", {31'h0, v[8 + flr_pkg::CS_RWWBUSY]}, 32'h1);
        cmd(flr_pkg::C_REEN, 16'h0040);
        fin(v);
        cmd(flr_pkg::C_LOAD, 16'h0040);
        fin(v);
        chk("reenabled load", {24'h0, v[7:0]}, {24'h0, 8'h40 ^ 8'ha5});
        // Lock write programs the zero bits, then the lock byte is read back
        wb(1'b1, flr_pkg::R_CMD, {16'h0, 8'hd7, 5'h0, flr_pkg::C_LOCKWR}, v);
        fin(v);
        cmd(flr_pkg::C_LOCKRD, flr_pkg::A_LOCK);
        fin(v);
        chk("written lock", {24'h0, v[7:0] & 8'h3f}, {26'h0, LK & 6'h17});
        // Read held back while the eeprom is busy
        ee <= 1'b1;
        cmd(flr_pkg::C_SIGNATURE_READ_SELECT, flr_pkg::A_SIG2);
        repeat (8) @(posedge mclk);
        ee <= 1'b0;
        fin(v);
        chk("held read", {24'h0, v[7:0]}, {24'h0, S2});
        complete_run();
    end
endmodule : test_fuse_lock_signature_readout
